// ==== hdl/caf_pkg.sv ====
// Package: register map, field layout and carriers for filter control 8..15
package caf_pkg;
  // Register byte addresses (chosen, no offset printed)
  localparam logic [7:0] CAF_OFS_CTRL2 = 8'h00;
  localparam logic [7:0] CAF_OFS_CTRL3 = 8'h04;
  localparam logic [7:0] CAF_OFS_STAT = 8'h08;
  localparam int CAF_ADDR_W = 8;
  // Field layout inside each filter byte
  localparam int CAF_EN_BIT = 7;
  localparam int CAF_MSK_HI = 6;
  localparam int CAF_MSK_LO = 5;
  localparam int CAF_DQ_HI = 4;
  localparam int CAF_DQ_LO = 0;
  localparam int CAF_FILT_PER_REG = 4;
  localparam int CAF_NFILT = 8;
  localparam int CAF_FIRST_FILT = 8;
  localparam int CAF_NMASK = 4;
  localparam int CAF_ID_W = 29;
  // Reset value and bus response codes
  localparam logic [31:0] CAF_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] CAF_RESP_OKAY = 2'h0;
  localparam logic [1:0] CAF_RESP_SLVERR = 2'h2;

  // One filter's control byte
  typedef struct packed {
    logic on;
    logic [1:0] mask_pick;
    logic [4:0] dest_queue;
  } caf_filt_s;

  // Incoming identifier to compare
  typedef struct packed {
    logic valid;
    logic [CAF_ID_W-1:0] id;
  } caf_rx_s;

  // Acceptance result
  typedef struct packed {
    logic hit;
    logic [2:0] filt;
    logic [4:0] dest_queue;
  } caf_hit_s;
endpackage : caf_pkg

// ==== hdl/caf_match.sv ====
// One filter's masked identifier comparator
`timescale 1ns/1ps
module caf_match
  import caf_pkg::*;
#(
  parameter int ID_W = CAF_ID_W
) (
  // Filter setup
  input wire caf_filt_s cfg_in,
  input wire logic [ID_W-1:0] ident_in,
  input wire logic [CAF_NMASK*ID_W-1:0] masks_in,
  // Frame identifier
  input wire logic [ID_W-1:0] rx_id_in,
  output logic match_out
);
  logic [ID_W-1:0] mask;

  // Mask picker: 00..11 select mask 0..3
  always_comb begin
    mask = masks_in[cfg_in.mask_pick*ID_W +: ID_W];
  end

  // Only masked bits compared; off filter never matches
  always_comb begin
    match_out = cfg_in.on &&
                (((rx_id_in ^ ident_in) & mask) == '0);
  end
endmodule : caf_match

// ==== hdl/caf_ctrl.sv ====
// Filter control registers 2 and 3 (filters 8..15) with AXI4-Lite slave
// Operation
// - Enable bit turns each filter on/off.
// - Register 2 holds filters 11,10,9,8 bytes.
// - Register 3 holds filters 15,14,13,12 bytes.
// - Mask select picks acceptance mask 0..3.
// - Queue select names destination FIFO 0..31.
// - All fields read/write, reset to zero.
`timescale 1ns/1ps
module caf_ctrl
  import caf_pkg::*;
#(
  parameter int ID_W = CAF_ID_W
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [CAF_ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [CAF_ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Filter identifiers and acceptance masks from neighbouring registers
  input wire logic [CAF_NFILT*ID_W-1:0] filt_ident_in,
  input wire logic [CAF_NMASK*ID_W-1:0] masks_in,
  // Received identifier (same clock domain)
  input wire caf_rx_s rx_in,
  // Per-filter setup to the engine
  output caf_filt_s [CAF_NFILT-1:0] filt_cfg_out,
  // Acceptance result, one-cycle pulse
  output caf_hit_s hit_out
);

  // Whole module state
  typedef struct packed {
    logic [31:0] ctrl2;
    logic [31:0] ctrl3;
    logic aw_got;
    logic [CAF_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    caf_hit_s hit;
    logic [4:0] last_q;
    logic [15:0] hit_cnt;
    logic last_hit;
    logic [2:0] last_filt;
    // Ready flags kept as flops so every bus output leaves a register
    logic awready;
    logic wready;
    logic arready;
  } caf_state_s;

  caf_state_s st_q;
  caf_state_s st_d;
  logic [CAF_NFILT-1:0] match;
  caf_filt_s [CAF_NFILT-1:0] cfg;

  // Unpack filter bytes: reg 2 low byte is filter 8, reg 3 low is 12
  always_comb begin
    for (int i = 0; i < CAF_FILT_PER_REG; i++) begin
      cfg[i] = st_q.ctrl2[i*8 +: 8];
      cfg[i+CAF_FILT_PER_REG] = st_q.ctrl3[i*8 +: 8];
    end
  end

  // One comparator per filter
  genvar g;
  generate
    for (g = 0; g < CAF_NFILT; g++) begin : g_match
      caf_match #(
        .ID_W(ID_W)
      ) u_match (
        .cfg_in(cfg[g]),
        .ident_in(filt_ident_in[g*ID_W +: ID_W]),
        .masks_in(masks_in),
        .rx_id_in(rx_in.id),
        .match_out(match[g])
      );
    end
  endgenerate

  // Byte-lane merge for a register write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Next-state logic: bus slave and acceptance
  always_comb begin
    logic do_wr;
    logic found;
    do_wr = 1'b0;
    found = 1'b0;
    st_d = st_q;
    // Address and data taken in either order, held until both present
    if (s_axi_awvalid && !st_q.aw_got && !st_q.bvalid) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_got && !st_q.bvalid) begin
      st_d.w_got = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      do_wr = 1'b1;
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = CAF_RESP_OKAY;
      unique case (st_q.aw_addr)
        CAF_OFS_CTRL2: st_d.ctrl2 = merge(st_q.ctrl2, st_q.w_data,
                                          st_q.w_strb);
        CAF_OFS_CTRL3: st_d.ctrl3 = merge(st_q.ctrl3, st_q.w_data,
                                          st_q.w_strb);
        CAF_OFS_STAT: st_d.bresp = CAF_RESP_OKAY; // Read-only; write data unused, write clears hit count below
        default: st_d.bresp = CAF_RESP_SLVERR;
      endcase
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    // Reads answer the cycle after the address is taken
    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = CAF_RESP_OKAY;
      unique case (s_axi_araddr)
        CAF_OFS_CTRL2: st_d.rdata = st_q.ctrl2;
        CAF_OFS_CTRL3: st_d.rdata = st_q.ctrl3;
        CAF_OFS_STAT: st_d.rdata = {st_q.hit_cnt, 3'h0, st_q.last_q,
                                    4'h0, st_q.last_hit, st_q.last_filt};
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = CAF_RESP_SLVERR;
        end
      endcase
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    // Lowest-numbered matching filter wins
    st_d.hit = '0;
    if (rx_in.valid) begin
      for (int i = 0; i < CAF_NFILT; i++) begin
        if (match[i] && !found) begin
          found = 1'b1;
          st_d.hit.hit = 1'b1;
          st_d.hit.filt = 3'(i);
          st_d.hit.dest_queue = cfg[i].dest_queue;
        end
      end
    end
    // Clear first so a hit in the same cycle is still counted
    if (do_wr && st_q.aw_addr == CAF_OFS_STAT) begin
      st_d.hit_cnt = 16'h0000; // Any write to status clears count
    end
    if (found) begin
      st_d.last_q = st_d.hit.dest_queue;
      st_d.last_hit = 1'b1;
      st_d.last_filt = st_d.hit.filt;
      st_d.hit_cnt = st_d.hit_cnt + 16'h0001;
    end
    // Writes to identifiers are the software's duty to gate
    // Ready flags follow the next holding state
    st_d.awready = !st_d.aw_got && !st_d.bvalid;
    st_d.wready = !st_d.w_got && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;
  end

  // State register; reset zeroes every field
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
      st_q.ctrl2 <= CAF_CTRL_RST;
      st_q.ctrl3 <= CAF_CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign filt_cfg_out = cfg;
  assign hit_out = st_q.hit;
endmodule : caf_ctrl

// ==== test/caf_ctrl_assertions.sv ====
// Checker: bus answers and acceptance results of caf_ctrl
`timescale 1ns/1ps
module caf_ctrl_assertions
  import caf_pkg::*;
(
  // Watched ports
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire caf_rx_s rx_in,
  input wire caf_filt_s [CAF_NFILT-1:0] filt_cfg_out,
  input wire caf_hit_s hit_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Reset setup and bus answers, one read in flight
  a_cfg_rst: assert property (
    $rose(reset_n_in) |-> filt_cfg_out == '0) else $error("setup not reset");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_rd_single: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  a_wr_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  // Hits need a frame and an enabled filter; queue must come from that filter
  a_hit_cause: assert property (hit_out.hit |-> $past(rx_in.valid))
    else $error("hit without frame");
  a_hit_on: assert property (hit_out.hit |->
    filt_cfg_out[hit_out.filt].on) else $error("hit from disabled filter");
  a_hit_queue: assert property (hit_out.hit |->
    hit_out.dest_queue == filt_cfg_out[hit_out.filt].dest_queue)
    else $error("wrong queue");
  a_off_quiet: assert property (rx_in.valid && filt_cfg_out == '0
    |=> !hit_out.hit) else $error("hit with all filters off");
endmodule : caf_ctrl_assertions

bind caf_ctrl caf_ctrl_assertions i_caf_ctrl_assertions (.*);

// ==== test/caf_ctrl_test.sv ====
// Bench: register access and acceptance of caf_ctrl
`timescale 1ns/1ps
module caf_ctrl_test
  import caf_pkg::*;
;
  // Bus, frame and result signals, idle at time zero
  logic sys_clk_in = '0, reset_n_in = '0, s_axi_awvalid = '0;
  logic s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [CAF_NFILT*CAF_ID_W-1:0] filt_ident_in = '0;
  // Mask m keeps only identifier bit m, so the pick is visible
  logic [CAF_NMASK*CAF_ID_W-1:0] masks_in = {29'h8, 29'h4, 29'h2, 29'h1};
  caf_rx_s rx_in = '0;
  caf_filt_s [CAF_NFILT-1:0] filt_cfg_out;
  caf_hit_s hit_out;
  int fails = 0, n_tests = 0;
  caf_ctrl i_caf_ctrl (.*);
  // 25 MHz clock
  always #20 sys_clk_in = ~sys_clk_in;
  // Compare and count
  task chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
          input logic [1:0] r = CAF_RESP_OKAY);
    @(posedge sys_clk_in);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, {r, e});
  endtask : rdc
  // One frame; result pulse checked the cycle after
  task rx(input logic [28:0] id, input logic [8:0] e);
    @(posedge sys_clk_in);
    rx_in <= {1'b1, id};
    @(posedge sys_clk_in);
    rx_in <= '0;
    #1 chk(e[8] ? 9'(hit_out) : {hit_out.hit, 8'h00}, e);
  endtask : rx
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    rdc(CAF_OFS_CTRL2, CAF_CTRL_RST, CAF_RESP_OKAY);
    rdc(CAF_OFS_CTRL3, CAF_CTRL_RST, CAF_RESP_OKAY);
    chk(filt_cfg_out, '0);
    // Filter 8 per mask: own bit refused, another bit passes
    for (int m = 0; m < CAF_NMASK; m++) begin
      wr(CAF_OFS_CTRL2, {24'h0, 1'b1, 2'(m), 5'(m * 8 + 7)}, 4'h1);
      rx(29'(1) << m, 9'h000);
      rx(29'(1) << ((m + 1) % 4), {4'h8, 5'(m * 8 + 7)});
    end
    wr(CAF_OFS_CTRL2, 32'h0, 4'hF);
    rx(29'h0, 9'h000);
    filt_ident_in[4*CAF_ID_W +: CAF_ID_W] <= 29'h1; // filter 12 identifier set to 1
    wr(CAF_OFS_CTRL3, 32'h95, 4'h1);
    rx(29'h1, {4'hC, 5'h15});
    rx(29'h0, 9'h000);
    rdc(CAF_OFS_STAT, 32'h0005_150C, CAF_RESP_OKAY);
    wr(CAF_OFS_STAT, 32'h0, 4'hF);
    rdc(CAF_OFS_STAT, 32'h0000_150C, CAF_RESP_OKAY);
    // Distinct pattern per field; partial strobes keep other bytes
    wr(CAF_OFS_CTRL2, 32'hE9B4_7F20, 4'hF);
    wr(CAF_OFS_CTRL3, 32'h1D8A_C5FF, 4'h5);
    rdc(CAF_OFS_CTRL2, 32'hE9B4_7F20, CAF_RESP_OKAY);
    rdc(CAF_OFS_CTRL3, 32'h008A_00FF, CAF_RESP_OKAY);
    chk(filt_cfg_out, 64'h008A_00FF_E9B4_7F20);
    wr(8'h0C, 32'hFFFF_FFFF, 4'hF, CAF_RESP_SLVERR);
    rdc(8'h0C, 32'h0, CAF_RESP_SLVERR);
    stop_test;
  end
  // Watchdog, far beyond the hundred or so cycles needed
  initial begin
    #100us;
    fails++;
    stop_test;
  end
endmodule : caf_ctrl_test
